// [hdl/sdc_pkg.sv]
// constants, state type and register map for the serial link receive core
// assumes a 100 MHz ref_clk; shared by the core, the lane deframer, the serializer model and the bench
package sdc_pkg;

    // ----------------------------------------
    // symbol and pixel layout
    // ----------------------------------------
    localparam int SYM_W     = 35;
    localparam int PAY_W     = 33;
    localparam int PIX_W     = 27;
    localparam int I2C_POS   = 27;
    localparam int GPIO_POS  = 28;
    localparam int GPIO_W    = 4;
    localparam int UI_N      = 7;
    localparam int PAIR_N    = 4;
    localparam logic [PAY_W-1:0] SCRAMBLE_MASK = 33'h0_5a3c_96e1;
    localparam logic [UI_N-1:0]  CLK_PATTERN   = 7'h63;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int REF_CLK_MHZ  = 100;
    localparam int STATIC_NS    = 2000;
    localparam int STATIC_CYC   = (STATIC_NS * REF_CLK_MHZ) / 1000;
    localparam int BC_SLOW_MBPS = 5;
    localparam int BC_FAST_MBPS = 20;
    localparam int BC_DIV_SLOW  = REF_CLK_MHZ / BC_SLOW_MBPS;
    localparam int BC_DIV_FAST  = REF_CLK_MHZ / BC_FAST_MBPS;
    localparam int BC_FRAME_W   = 11;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_CFG    = 8'h02;
    localparam logic [7:0] ADDR_GPCFG  = 8'h1d;
    localparam logic [7:0] ADDR_PSEL   = 8'h34;
    localparam logic [7:0] ADDR_MODE   = 8'h58;
    localparam logic [7:0] ADDR_STAT   = 8'h5a;
    localparam int CFG_OE_BIT    = 7;
    localparam int CFG_OSC_BIT   = 5;
    localparam int CFG_SLEEP_BIT = 4;
    localparam int MODE_LANE_BIT = 0;
    localparam int MODE_LVDS_BIT = 1;
    localparam logic [7:0] CFG_RST   = 8'h90;
    localparam logic [1:0] PSEL_RST  = 2'h1;
    localparam logic [7:0] MODE_RST  = 8'h00;
    localparam logic [7:0] GPCFG_RST = 8'h00;

    typedef enum logic [2:0] {
        ST_OFF    = 3'b001,
        ST_ACQ    = 3'b010,
        ST_LOCKED = 3'b100
    } sdc_state_t;

endpackage

// [hdl/sdc_deframer.sv]
// one serial lane: symbol framing on embedded clock bits, lock and descramble
// assumes bit_i and strobe_i already live in the ref_clk domain
`timescale 1ns/1ps
module sdc_deframer import sdc_pkg::*; #(
    parameter int LOCK_GOOD = 4
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // sampled lane
    input  wire logic             bit_i,
    input  wire logic             strobe_i,
    // recovered symbols
    output logic [PAY_W-1:0]      payload_o,
    output logic                  sym_valid_o,
    output logic                  locked_o
);
    logic [SYM_W-1:0] sh_q;
    logic [SYM_W-1:0] sh_d;
    logic [5:0]       cnt_q;
    logic [3:0]       good_q;
    logic             boundary;
    logic             frame_ok;

    assign sh_d     = {bit_i, sh_q[SYM_W-1:1]};
    assign boundary = (cnt_q == 6'(SYM_W - 1));
    // first bit is the high clock bit, last the low one
    assign frame_ok = sh_d[0] & ~sh_d[SYM_W-1];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sh_q <= '0;
        end else if (strobe_i) begin
            sh_q <= sh_d;
        end
    end

    // no reference clock, no training: hunt any bit position for framing
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_q       <= '0;
            good_q      <= '0;
            locked_o    <= 1'b0;
            sym_valid_o <= 1'b0;
            payload_o   <= '0;
        end else begin
            sym_valid_o <= 1'b0;
            if (strobe_i) begin
                cnt_q <= boundary ? 6'h00 : cnt_q + 6'h01;
                if (!locked_o) begin
                    if (frame_ok && (good_q == 4'h0 || boundary)) begin
                        cnt_q  <= 6'h00;
                        good_q <= good_q + 4'h1;
                        locked_o <= (good_q == 4'(LOCK_GOOD - 1));
                    end else if (boundary) begin
                        good_q <= 4'h0;
                    end
                end else if (boundary) begin
                    if (frame_ok) begin
                        sym_valid_o <= 1'b1;
                        payload_o   <= sh_d[SYM_W-2:1] ^ SCRAMBLE_MASK;
                    end else begin
                        locked_o <= 1'b0;
                        good_q   <= 4'h0;
                    end
                end
            end
        end
    end
endmodule

// [hdl/sdc_fifo.sv]
// small synchronous fifo, flip-flop storage, depth a power of two
// assumes one clock; push ignored when full, pop ignored when empty
`timescale 1ns/1ps
module sdc_fifo #(
    parameter int W = 27,
    parameter int D = 8
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_ready & out_valid;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// [hdl/sdc_core.sv]
// receive core of a serial video link: lanes in, lvds display pairs out
// assumes the link, power-down and strap pins are asynchronous to ref_clk and the link clock is far slower
`timescale 1ns/1ps
module sdc_core import sdc_pkg::*; #(
    parameter int FIFO_D       = 8,
    parameter int LOCK_GOOD    = 4,
    parameter int LINK_MIN_CYC = 2,
    parameter int LINK_MAX_CYC = 64
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // serial link pins
    input  wire logic        link_clk_pin,
    input  wire logic [1:0]  lane_pin,
    output logic [1:0]       bc_lane_o,
    output logic [1:0]       bc_lane_oe,
    // power and straps
    input  wire logic        powerdown_n_input,
    input  wire logic        backchannel_rate_strap,
    // local host register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    output logic             reg_rvalid,
    // back channel sources
    input  wire logic        bc_i2c_i,
    input  wire logic [3:0]  bc_gpio_i,
    // lvds display interface
    output logic [7:0]       lvds_data_pair,
    output logic             lvds_data_oe,
    output logic [1:0]       lvds_clk_pair,
    output logic             lvds_clk_oe,
    // status and forwarded sidebands
    output logic             lock_o,
    output logic             lock_oe,
    output logic [3:0]       gpio_o,
    output logic             gpio_oe,
    output logic             fwd_i2c_o,
    output logic             overflow_o
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    localparam int PIN_N    = 5;
    localparam int PIN_LCLK = 0;
    localparam int PIN_L0   = 1;
    localparam int PIN_PDB  = 3;
    localparam int PIN_STRP = 4;

    logic [PIN_N-1:0] pin_v;
    logic [PIN_N-1:0] meta_q;
    logic [PIN_N-1:0] sync_q;

    assign pin_v = {backchannel_rate_strap, powerdown_n_input, lane_pin, link_clk_pin};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_N; gi++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= pin_v[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // power-down, strap and link edges
    // ----------------------------------------
    logic pd_n;
    logic irst;
    logic pd_prev_q;
    logic bc_fast_q;
    logic lclk_prev_q;
    logic link_rise;

    assign pd_n      = sync_q[PIN_PDB];
    assign irst      = rst | ~pd_n;
    assign link_rise = sync_q[PIN_LCLK] & ~lclk_prev_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pd_prev_q   <= 1'b0;
            lclk_prev_q <= 1'b0;
        end else begin
            pd_prev_q   <= pd_n;
            lclk_prev_q <= sync_q[PIN_LCLK];
        end
    end

    // strap is caught on release of power-down, not under reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bc_fast_q <= 1'b0;
        end else if (pd_n && !pd_prev_q) begin
            bc_fast_q <= sync_q[PIN_STRP];
        end
    end

    // ----------------------------------------
    // link rate and static monitor
    // ----------------------------------------
    logic [7:0]  per_q;
    logic        rate_ok_q;
    logic [15:0] idle_q;
    logic        static_q;

    always_ff @(posedge ref_clk) begin
        if (irst) begin
            per_q     <= '0;
            rate_ok_q <= 1'b0;
        end else if (link_rise) begin
            per_q     <= '0;
            rate_ok_q <= (per_q >= 8'(LINK_MIN_CYC - 1)) && (per_q <= 8'(LINK_MAX_CYC - 1));
        end else if (per_q != 8'hff) begin
            per_q <= per_q + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (irst) begin
            idle_q   <= '0;
            static_q <= 1'b1;
        end else if (link_rise) begin
            idle_q   <= '0;
            static_q <= 1'b0;
        end else if (idle_q == 16'(STATIC_CYC)) begin
            static_q <= 1'b1;
        end else begin
            idle_q <= idle_q + 16'h0001;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] cfg_q;
    logic [1:0] psel_q;
    logic [7:0] mode_q;
    logic [7:0] gpcfg_q [2];
    logic [1:0] lane_lock;
    logic       dual_lane;
    logic       dual_lvds;
    logic       rd_port;

    function automatic logic is_dup(input logic [7:0] a);
        return (a == ADDR_GPCFG) || (a == ADDR_STAT);
    endfunction

    assign dual_lane = mode_q[MODE_LANE_BIT];
    assign dual_lvds = mode_q[MODE_LVDS_BIT];
    assign rd_port   = psel_q[1];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_q  <= CFG_RST;
            psel_q <= PSEL_RST;
            mode_q <= MODE_RST;
        end else if (reg_wr && !is_dup(reg_addr)) begin
            if (reg_addr == ADDR_CFG) begin
                cfg_q <= reg_wdata;
            end else if (reg_addr == ADDR_PSEL) begin
                psel_q <= reg_wdata[1:0];
            end else if (reg_addr == ADDR_MODE) begin
                mode_q <= reg_wdata;
            end
        end
    end

    generate
        for (gi = 0; gi < 2; gi++) begin : g_dup
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    gpcfg_q[gi] <= GPCFG_RST;
                end else if (reg_wr && reg_addr == ADDR_GPCFG && psel_q[gi]) begin
                    gpcfg_q[gi] <= reg_wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata  <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (!reg_rd) begin
                reg_rdata <= reg_rdata;
            end else if (reg_addr == ADDR_CFG) begin
                reg_rdata <= cfg_q;
            end else if (reg_addr == ADDR_PSEL) begin
                reg_rdata <= {6'h00, psel_q};
            end else if (reg_addr == ADDR_MODE) begin
                reg_rdata <= mode_q;
            end else if (reg_addr == ADDR_GPCFG) begin
                reg_rdata <= gpcfg_q[rd_port];
            end else if (reg_addr == ADDR_STAT) begin
                reg_rdata <= {5'h00, static_q, rate_ok_q, lane_lock[rd_port]};
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ----------------------------------------
    // lane deframers and fifo fill
    // ----------------------------------------
    logic [PAY_W-1:0] pay [2];
    logic [1:0]       sym_v;
    logic [PIX_W-1:0] pend_q;
    logic             pend_v_q;
    logic             f_in_valid;
    logic             f_in_ready;
    logic [PIX_W-1:0] f_in_data;
    logic             f_out_valid;
    logic             f_out_ready;
    logic [PIX_W-1:0] f_out_data;
    logic             lock_int;

    generate
        for (gi = 0; gi < 2; gi++) begin : g_lane
            sdc_deframer #(
                .LOCK_GOOD   (LOCK_GOOD)
            ) u_deframer (
                .ref_clk     (ref_clk),
                .rst         (irst),
                .bit_i       (sync_q[PIN_L0 + gi]),
                .strobe_i    (link_rise),
                .payload_o   (pay[gi]),
                .sym_valid_o (sym_v[gi]),
                .locked_o    (lane_lock[gi])
            );
        end
    endgenerate

    // both lanes finish together; the second word waits one cycle
    assign f_in_valid = sym_v[0] | pend_v_q;
    assign f_in_data  = sym_v[0] ? pay[0][PIX_W-1:0] : pend_q;
    assign lock_int   = lane_lock[0] & (lane_lock[1] | ~dual_lane) & rate_ok_q & ~static_q;

    always_ff @(posedge ref_clk) begin
        if (irst) begin
            pend_q   <= '0;
            pend_v_q <= 1'b0;
        end else begin
            pend_v_q <= sym_v[1] & dual_lane;
            pend_q   <= pay[1][PIX_W-1:0];
        end
    end

    // the link cannot be paused, so a refused push is counted as lost
    always_ff @(posedge ref_clk) begin
        if (irst) begin
            overflow_o <= 1'b0;
        end else if (f_in_valid && !f_in_ready) begin
            overflow_o <= 1'b1;
        end
    end

    sdc_fifo #(
        .W         (PIX_W),
        .D         (FIFO_D)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (irst),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    // ----------------------------------------
    // lock state
    // ----------------------------------------
    sdc_state_t st_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= ST_OFF;
        end else begin
            case (st_q)
                ST_OFF:    st_q <= pd_n ? ST_ACQ : ST_OFF;
                ST_ACQ:    st_q <= !pd_n ? ST_OFF : (lock_int ? ST_LOCKED : ST_ACQ);
                ST_LOCKED: st_q <= !pd_n ? ST_OFF : (lock_int ? ST_LOCKED : ST_ACQ);
                default:   st_q <= ST_OFF;
            endcase
        end
    end

    // ----------------------------------------
    // lvds serialiser
    // ----------------------------------------
    localparam int WORD_W = UI_N * PAIR_N;

    logic [2:0]        ui_q;
    logic              ui_last;
    logic [PIX_W-1:0]  cur_pix;
    logic [PIX_W-1:0]  wa_q;
    logic [WORD_W-1:0] word_a;
    logic [WORD_W-1:0] word_b;
    logic [UI_N-1:0]   sh_q [2*PAIR_N];

    assign ui_last     = (ui_q == 3'(UI_N - 1));
    assign cur_pix     = f_out_valid ? f_out_data : '0;
    assign f_out_ready = ui_last | (dual_lvds & (ui_q == 3'(UI_N - 2)));
    assign word_a      = {1'b0, dual_lvds ? wa_q : cur_pix};
    assign word_b      = dual_lvds ? {1'b0, cur_pix} : '0;

    always_ff @(posedge ref_clk) begin
        if (irst) begin
            ui_q <= '0;
            wa_q <= '0;
        end else begin
            ui_q <= ui_last ? 3'h0 : ui_q + 3'h1;
            if (f_out_ready) begin
                wa_q <= cur_pix;
            end
        end
    end

    generate
        for (gi = 0; gi < 2 * PAIR_N; gi++) begin : g_pair
            always_ff @(posedge ref_clk) begin
                if (irst) begin
                    sh_q[gi] <= '0;
                end else if (ui_last) begin
                    sh_q[gi] <= (gi < PAIR_N) ? word_a[UI_N*(gi%PAIR_N) +: UI_N]
                                              : word_b[UI_N*(gi%PAIR_N) +: UI_N];
                end else begin
                    sh_q[gi] <= {1'b0, sh_q[gi][UI_N-1:1]};
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // output pin states
    // ----------------------------------------
    logic       oe_cfg;
    logic       sleep_sel;
    logic       valid_out;
    logic       clk_bit;
    logic [7:0] data_bits;

    assign oe_cfg    = cfg_q[CFG_OE_BIT];
    assign sleep_sel = cfg_q[CFG_SLEEP_BIT];
    assign valid_out = (st_q == ST_LOCKED) & oe_cfg & sleep_sel;
    assign clk_bit   = CLK_PATTERN[ui_q];

    generate
        for (gi = 0; gi < 2 * PAIR_N; gi++) begin : g_bits
            assign data_bits[gi] = sh_q[gi][0];
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (rst || st_q == ST_OFF) begin
            lock_oe      <= 1'b0;
            lvds_data_oe <= 1'b0;
            lvds_clk_oe  <= 1'b0;
            gpio_oe      <= 1'b0;
            lock_o       <= 1'b0;
            lvds_data_pair <= '0;
            lvds_clk_pair  <= '0;
            gpio_o       <= '0;
            fwd_i2c_o    <= 1'b0;
        end else begin
            lock_oe      <= oe_cfg | ~sleep_sel || sleep_sel;
            lvds_data_oe <= oe_cfg | ~sleep_sel;
            lvds_clk_oe  <= oe_cfg | ~sleep_sel;
            gpio_oe      <= (oe_cfg | ~sleep_sel) & (gpcfg_q[0] != 8'h00);
            lock_o       <= (st_q == ST_LOCKED) & (sleep_sel | oe_cfg) & ~(oe_cfg & ~sleep_sel);
            lvds_data_pair <= valid_out ? data_bits : 8'h00;
            if (valid_out) begin
                lvds_clk_pair <= {dual_lvds & clk_bit, clk_bit};
            end else if (oe_cfg && !sleep_sel && static_q && cfg_q[CFG_OSC_BIT]) begin
                lvds_clk_pair <= {clk_bit, clk_bit};
            end else begin
                lvds_clk_pair <= 2'h0;
            end
            if (valid_out && sym_v[0]) begin
                gpio_o    <= pay[0][GPIO_POS +: GPIO_W];
                fwd_i2c_o <= pay[0][I2C_POS];
            end else if (!valid_out) begin
                gpio_o    <= '0;
                fwd_i2c_o <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // back channel transmitter
    // ----------------------------------------
    logic [4:0]            bdiv_q;
    logic [3:0]            bbit_q;
    logic [BC_FRAME_W-1:0] bfr_q;
    logic [3:0]            crc;
    logic                  btick;

    assign crc   = {bc_gpio_i[3] ^ bc_i2c_i, bc_gpio_i[3:1] ^ bc_gpio_i[2:0]} ^ 4'ha;
    assign btick = (bdiv_q == (bc_fast_q ? 5'(BC_DIV_FAST - 1) : 5'(BC_DIV_SLOW - 1)));

    always_ff @(posedge ref_clk) begin
        if (irst) begin
            bdiv_q <= '0;
            bbit_q <= '0;
            bfr_q  <= '0;
        end else begin
            bdiv_q <= btick ? 5'h00 : bdiv_q + 5'h01;
            if (btick && bbit_q == 4'h0) begin
                bfr_q  <= {1'b0, crc, bc_gpio_i, bc_i2c_i, 1'b1};
                bbit_q <= 4'(BC_FRAME_W - 1);
            end else if (btick) begin
                bfr_q  <= {1'b0, bfr_q[BC_FRAME_W-1:1]};
                bbit_q <= bbit_q - 4'h1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (irst) begin
            bc_lane_o  <= '0;
            bc_lane_oe <= '0;
        end else begin
            bc_lane_o  <= {2{bfr_q[0]}};
            bc_lane_oe <= {dual_lane, 1'b1};
        end
    end
endmodule

// [verification/sdc_ser_model.sv]
// serializer stand-in: symbols with embedded clock bits on both lanes
// assumes the bench holds pay steady; link clock stands still while en is low
`timescale 1ns/1ps
module sdc_ser_model import sdc_pkg::*; (
    // control from bench
    input  wire logic             en,
    input  wire logic [PAY_W-1:0] pay,
    // link pins
    output logic                  link_clk_pin,
    output logic [1:0]            lane_pin
);
    logic [SYM_W-1:0] sym;
    initial begin
        link_clk_pin = 1'b0;
        lane_pin = 2'h0;
        forever begin
            // idle lanes keep changing so a held last bit never looks valid
            lane_pin = ~lane_pin;
            #40;
            while (en) begin
                sym = {1'b0, pay ^ SCRAMBLE_MASK, 1'b1};
                for (int k = 0; k < SYM_W; k++) begin
                    lane_pin = {2{sym[k]}};
                    #40 link_clk_pin = 1'b1;
                    #40 link_clk_pin = 1'b0;
                end
            end
        end
    end
endmodule

// [verification/sdc_core_chk.sv]
// checker: timing relations at the receive core ports
// assumes a bind onto sdc_core, one clock domain
`timescale 1ns/1ps
module sdc_core_chk (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // watched ports
    input wire logic       reg_rd,
    input wire logic       reg_rvalid,
    input wire logic [7:0] reg_rdata,
    input wire logic       powerdown_n_input,
    input wire logic       lock_o,
    input wire logic       lock_oe,
    input wire logic [7:0] lvds_data_pair,
    input wire logic       lvds_data_oe,
    input wire logic [1:0] lvds_clk_pair,
    input wire logic [3:0] gpio_o
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_low3; !lvds_clk_pair[0] [*3]; endsequence
    // two unlocked cycles: allows the output register one cycle to catch up
    sequence s_idle; !lock_o && !$past(lock_o); endsequence
    property p_rv; reg_rd |=> reg_rvalid; endproperty
    a_rv: assert property (p_rv) else $error("no rvalid");
    property p_norv; !reg_rd |=> !reg_rvalid; endproperty
    a_norv: assert property (p_norv) else $error("stray rvalid");
    property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("rdata moved");
    property p_pdn; !powerdown_n_input [*5] |-> !lock_oe && !lvds_data_oe; endproperty
    a_pdn: assert property (p_pdn) else $error("driving in power-down");
    property p_data; s_idle |-> lvds_data_pair == 8'h00; endproperty
    a_data: assert property (p_data) else $error("data while unlocked");
    property p_gpio; s_idle |-> gpio_o == 4'h0; endproperty
    a_gpio: assert property (p_gpio) else $error("gpio while unlocked");
    property p_clk;
        $fell(lvds_clk_pair[0]) && lock_o |-> s_low3 ##1 (lvds_clk_pair[0] || !lock_o);
    endproperty
    a_clk: assert property (p_clk) else $error("clock pattern");
    property p_lockoe; lock_o |-> lock_oe; endproperty
    a_lockoe: assert property (p_lockoe) else $error("lock not driven");
endmodule

// [verification/test_sdc_core.sv]
// bench: register port, lock, pixel path, stream loss, power-down
// assumes the serializer model drives the lanes
`timescale 1ns/1ps
module test_sdc_core import sdc_pkg::*; ;
    logic             ref_clk = 1'b0, rst = 1'b1, en = 1'b0, powerdown_n_input = 1'b0;
    logic             reg_wr = 1'b0, reg_rd = 1'b0, backchannel_rate_strap = 1'b0;
    logic             bc_i2c_i = 1'b1, link_clk_pin, reg_rvalid, lvds_data_oe, lvds_clk_oe;
    logic             lock_o, lock_oe, gpio_oe, fwd_i2c_o, overflow_o;
    logic [1:0]       lane_pin, bc_lane_o, bc_lane_oe, lvds_clk_pair;
    logic [3:0]       bc_gpio_i = 4'h5, gpio_o;
    logic [7:0]       reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, lvds_data_pair;
    logic [PAY_W-1:0] pay = 33'h0_953c_a5f0;
    logic [27:0]      got = 28'h0;
    int               fails = 0, num_checks = 0, i, f, k, p;
    always #5 ref_clk = ~ref_clk;
    sdc_ser_model sdc_ser_model_i (.*);
    sdc_core #(.FIFO_D(8), .LOCK_GOOD(4)) sdc_core_i (.*);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] s);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        if (!w)
            chk("reg_read", {19'h0, 1'b1, d}, {19'h0, reg_rvalid, reg_rdata});
    endtask
    function automatic logic pick(input int w);
        return w ? lvds_clk_pair[0] : lock_o;
    endfunction
    // bounded wait; running out ends the run
    task automatic wait_on(input int w, input logic v);
        for (i = 0; i < 4000 && pick(w) !== v; i++)
            @(negedge ref_clk);
        chk(w ? "lvds_clk_pair" : "lock_o", 28'(v), 28'(pick(w)));
        if (pick(w) !== v)
            print_verdict();
    endtask
    task automatic print_verdict();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        acc(0, ADDR_CFG, CFG_RST);
        acc(0, ADDR_PSEL, {6'h00, PSEL_RST});
        acc(0, 8'h77, 8'h00);
        acc(1, ADDR_PSEL, 8'h03);
        acc(1, ADDR_GPCFG, 8'ha5);
        acc(1, ADDR_PSEL, 8'h02);
        acc(1, ADDR_GPCFG, 8'h3c);
        acc(0, ADDR_CFG, CFG_RST);
        acc(1, ADDR_PSEL, 8'h03);
        acc(0, ADDR_GPCFG, 8'h3c);
        acc(1, ADDR_PSEL, 8'h01);
        acc(0, ADDR_GPCFG, 8'ha5);
        powerdown_n_input = 1'b1;
        en = 1'b1;
        wait_on(0, 1'b1);
        chk("oe", 28'h3d, 28'({lock_oe, lvds_data_oe, lvds_clk_oe, gpio_oe, bc_lane_oe}));
        wait_on(1, 1'b0);
        wait_on(1, 1'b1);
        // rise of the clock pair marks unit 5; two more reach unit 0
        repeat (2) @(negedge ref_clk);
        for (f = 0; f < 90 && got === 28'h0; f++)
            for (k = 0; k < 7; k++) begin
                for (p = 0; p < 4; p++)
                    got[7 * p + k] = lvds_data_pair[p];
                @(negedge ref_clk);
            end
        chk("pixel", {1'b0, pay[PIX_W-1:0]}, got);
        chk("gpio_o", 28'(pay[GPIO_POS +: GPIO_W]), 28'(gpio_o));
        chk("fwd_i2c_o", 28'(pay[I2C_POS]), 28'(fwd_i2c_o));
        chk("overflow_o", 28'h0, 28'(overflow_o));
        acc(0, ADDR_STAT, 8'h03);
        // one back-channel frame period at the slow rate holds eight level changes
        k = bc_lane_o[0];
        p = 0;
        for (f = 0; f < 220; f++) begin
            @(negedge ref_clk);
            p += (bc_lane_o[0] != k);
            k = bc_lane_o[0];
        end
        chk("bc_edges", 28'h8, 28'(p));
        en = 1'b0;
        wait_on(0, 1'b0);
        acc(1, ADDR_CFG, 8'ha0);
        chk("lvds_data_pair", 28'h0, 28'(lvds_data_pair));
        wait_on(1, 1'b1);
        powerdown_n_input = 1'b0;
        repeat (5) @(negedge ref_clk);
        chk("oe", 28'h0, 28'({lock_oe, lvds_data_oe, lvds_clk_oe, gpio_oe, bc_lane_oe}));
        acc(0, ADDR_CFG, 8'ha0);
        print_verdict();
    end
endmodule
bind sdc_core sdc_core_chk sdc_core_chk_i (.*);
